// ---- src/rah_host.sv ----
// Reverse address resolution requester with AXI4-Lite control
// Functional notes
// - Header: 16-bit hardware and protocol space, 8-bit lengths, 16-bit opcode.
// - Each hardware address field is as long as the hardware length.
// - Each protocol address field is as long as the protocol length.
// - Ethernet and internet use codes 1 and 2048, lengths 6 and 4.
// - Reverse packets use their own frame type, unlike forward resolution.
// - Opcode 3 is reverse request, opcode 4 is reverse reply.
// - Request source hardware is the sender; source and target protocol ignored.
// - Request target hardware names the station; self lookup uses own address.
// - Reply source hardware is the server's hardware address.
// - Reply source protocol is the server's own protocol address.
// - Reply target hardware repeats the request's target hardware.
// - Reply target protocol carries the resolved address.
// - Header words go most significant byte first, no padding.
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
module rah_host
#(
  parameter logic [15:0] rev_frame_type = 16'h5a01,
  parameter logic [15:0] fwd_frame_type = 16'h5a02,
  parameter int          timeout_cyc    = rah_pkg::RAH_TIMEOUT_CYC
)
(
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_b,
  // AXI4-Lite write channels
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output logic [1:0]                 s_axi_bresp,
  // AXI4-Lite read channels
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  input  wire logic [7:0]            s_axi_araddr,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  // Transmit byte stream
  output logic                       tx_valid,
  output rah_pkg::rah_byte_type      tx_byte,
  input  wire logic                  tx_ready,
  // Receive byte stream
  input  wire logic                  rx_valid,
  input  wire rah_pkg::rah_byte_type rx_byte,
  // Forward resolution hand-off
  output logic                       fwd_valid,
  output rah_pkg::rah_pkt_type       fwd_pkt
);
  import rah_pkg::*;

  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_WAIT} rah_state_type;

  // ==========================================================
  // Helpers
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    return r;
  endfunction

  function automatic logic hdr_ok(input rah_pkt_type p);
    return p.hrd == RAH_HRD_ETH && p.pro == RAH_PRO_IP
           && p.hln == RAH_HLN && p.pln == RAH_PLN;
  endfunction

  // ==========================================================
  // Registers
  rah_state_type state_q;
  logic [47:0]   own_ha_q;
  logic [47:0]   tgt_ha_q;
  logic [31:0]   res_pa_q;
  logic [31:0]   srv_pa_q;
  logic [47:0]   srv_ha_q;
  logic          done_q;
  logic          tout_q;
  logic          fwdseen_q;
  logic          badop_q;
  logic [31:0]   timer_q;
  logic [239:0]  tx_img_q;
  logic [4:0]    tx_idx_q;
  logic          aw_full_q;
  logic          w_full_q;
  logic [7:0]    awaddr_q;
  logic [31:0]   wdata_q;
  logic [3:0]    wstrb_q;
  logic          wr_go;
  logic          start;
  logic [4:0]    clr;
  logic          rx_pkt_valid;
  rah_pkt_type   rx_pkt;
  logic          rx_rev;
  logic          reply_hit;
  logic          fwd_hit;
  logic          bad_hit;
  logic          expire;

  // ==========================================================
  // Receive parser
  rah_rx_parse u_rx
  (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .rx_valid  (rx_valid),
    .rx_byte   (rx_byte),
    .pkt_valid (rx_pkt_valid),
    .pkt       (rx_pkt)
  );

  // ==========================================================
  // Received packet classification
  assign rx_rev    = rx_pkt_valid && rx_pkt.ftype == rev_frame_type
                     && hdr_ok(rx_pkt);
  assign reply_hit = rx_rev && rx_pkt.op == RAH_OP_RREP && state_q == TX_WAIT
                     && rx_pkt.tha == tgt_ha_q;
  assign fwd_hit   = rx_pkt_valid && (rx_pkt.op == RAH_OP_FREQ
                     || rx_pkt.op == RAH_OP_FREP);
  assign bad_hit   = rx_pkt_valid && (rx_pkt.op == 16'h0000
                     || rx_pkt.op > RAH_OP_RREP);
  assign expire    = state_q == TX_WAIT && timer_q == 32'h00000001;

  // ==========================================================
  // AXI4-Lite write path
  assign wr_go = aw_full_q && w_full_q && !s_axi_bvalid;
  assign start = wr_go && awaddr_q == RAH_REG_CTRL && wstrb_q[0]
                 && wdata_q[RAH_CTRL_START] && state_q == TX_IDLE;
  assign clr   = (wr_go && awaddr_q == RAH_REG_STATUS && wstrb_q[0])
                 ? wdata_q[4:0] : 5'h00;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awaddr_q      <= s_axi_awaddr;
        aw_full_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        w_full_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        aw_full_q     <= 1'b0;
        w_full_q      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= (awaddr_q[1:0] != 2'h0 || awaddr_q > RAH_REG_SRV_HI)
                         ? 2'h2 : 2'h0;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Software-owned addresses
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      own_ha_q <= '0;
      tgt_ha_q <= '0;
    end
    else if (wr_go && state_q == TX_IDLE)
    begin
      unique case (awaddr_q)
        RAH_REG_OWN_LO: own_ha_q[31:0]  <= merge(own_ha_q[31:0], wdata_q, wstrb_q);
        RAH_REG_OWN_HI: own_ha_q[47:32] <= 16'(merge({16'h0000, own_ha_q[47:32]},
                                                     wdata_q, wstrb_q));
        RAH_REG_TGT_LO: tgt_ha_q[31:0]  <= merge(tgt_ha_q[31:0], wdata_q, wstrb_q);
        RAH_REG_TGT_HI: tgt_ha_q[47:32] <= 16'(merge({16'h0000, tgt_ha_q[47:32]},
                                                     wdata_q, wstrb_q));
        default: ;
      endcase
    end
  end

  // ==========================================================
  // AXI4-Lite read path
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= 2'h0;
      unique case (s_axi_araddr)
        RAH_REG_CTRL:   s_axi_rdata <= 32'h00000000;
        RAH_REG_STATUS: s_axi_rdata <= {27'h0000000, badop_q, fwdseen_q, tout_q,
                                        done_q, state_q != TX_IDLE};
        RAH_REG_OWN_LO: s_axi_rdata <= own_ha_q[31:0];
        RAH_REG_OWN_HI: s_axi_rdata <= {16'h0000, own_ha_q[47:32]};
        RAH_REG_TGT_LO: s_axi_rdata <= tgt_ha_q[31:0];
        RAH_REG_TGT_HI: s_axi_rdata <= {16'h0000, tgt_ha_q[47:32]};
        RAH_REG_RES_PA: s_axi_rdata <= res_pa_q;
        RAH_REG_SRV_PA: s_axi_rdata <= srv_pa_q;
        RAH_REG_SRV_LO: s_axi_rdata <= srv_ha_q[31:0];
        RAH_REG_SRV_HI: s_axi_rdata <= {16'h0000, srv_ha_q[47:32]};
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // Request sequencing and transmit
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q  <= TX_IDLE;
      tx_img_q <= '0;
      tx_idx_q <= 5'h00;
      tx_valid <= 1'b0;
      tx_byte  <= '0;
    end
    else
    begin
      unique case (state_q)
        TX_IDLE:
          if (start)
          begin
            tx_img_q <= {rev_frame_type, RAH_HRD_ETH, RAH_PRO_IP, RAH_HLN, RAH_PLN,
                         RAH_OP_RREQ, own_ha_q, 32'h00000000, tgt_ha_q,
                         32'h00000000};
            tx_idx_q <= 5'h00;
            state_q  <= TX_SEND;
          end
        TX_SEND:
          if (!tx_valid || tx_ready)
          begin
            if (tx_valid && tx_byte.last)
            begin
              tx_valid <= 1'b0;
              state_q  <= TX_WAIT;
            end
            else
            begin
              tx_valid     <= 1'b1;
              tx_byte.data <= tx_img_q[239:232];
              tx_byte.last <= tx_idx_q == RAH_PKT_BYTES - 5'h01;
              tx_img_q     <= {tx_img_q[231:0], 8'h00};
              tx_idx_q     <= tx_idx_q + 5'h01;
            end
          end
        TX_WAIT:
          if (reply_hit || expire)
            state_q <= TX_IDLE;
      endcase
    end
  end

  // Reply timeout countdown
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      timer_q <= 32'h00000000;
    else if (state_q != TX_WAIT)
      timer_q <= 32'(timeout_cyc);
    else if (timer_q != 32'h00000000)
      timer_q <= timer_q - 32'h00000001;
  end

  // ==========================================================
  // Reply capture
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      res_pa_q <= 32'h00000000;
      srv_pa_q <= 32'h00000000;
      srv_ha_q <= '0;
    end
    else if (reply_hit)
    begin
      res_pa_q <= rx_pkt.tpa;
      srv_pa_q <= rx_pkt.spa;
      srv_ha_q <= rx_pkt.sha;
    end
  end

  // Sticky status, set wins over clear
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      done_q    <= 1'b0;
      tout_q    <= 1'b0;
      fwdseen_q <= 1'b0;
      badop_q   <= 1'b0;
    end
    else
    begin
      done_q    <= reply_hit || (done_q && !clr[RAH_ST_DONE]);
      tout_q    <= (expire && !reply_hit) || (tout_q && !clr[RAH_ST_TOUT]);
      fwdseen_q <= fwd_hit || (fwdseen_q && !clr[RAH_ST_FWD]);
      badop_q   <= bad_hit || (badop_q && !clr[RAH_ST_BADOP]);
    end
  end

  // ==========================================================
  // Forward resolution hand-off
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fwd_valid <= 1'b0;
      fwd_pkt   <= '0;
    end
    else
    begin
      fwd_valid <= fwd_hit;
      if (fwd_hit)
        fwd_pkt <= rx_pkt;
    end
  end

endmodule

// ---- pkg/rah_pkg.sv ----
// Package of constants and carriers for the reverse address resolution host
package rah_pkg;

  // ==========================================================
  // Packet header values
  localparam logic [15:0] RAH_HRD_ETH   = 16'h0001;
  localparam logic [15:0] RAH_PRO_IP    = 16'h0800;
  localparam logic [7:0]  RAH_HLN       = 8'h06;
  localparam logic [7:0]  RAH_PLN       = 8'h04;
  localparam logic [15:0] RAH_OP_FREQ   = 16'h0001;
  localparam logic [15:0] RAH_OP_FREP   = 16'h0002;
  localparam logic [15:0] RAH_OP_RREQ   = 16'h0003;
  localparam logic [15:0] RAH_OP_RREP   = 16'h0004;
  localparam logic [4:0]  RAH_PKT_BYTES = 5'h1e;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] RAH_REG_CTRL    = 8'h00;
  localparam logic [7:0] RAH_REG_STATUS  = 8'h04;
  localparam logic [7:0] RAH_REG_OWN_LO  = 8'h08;
  localparam logic [7:0] RAH_REG_OWN_HI  = 8'h0c;
  localparam logic [7:0] RAH_REG_TGT_LO  = 8'h10;
  localparam logic [7:0] RAH_REG_TGT_HI  = 8'h14;
  localparam logic [7:0] RAH_REG_RES_PA  = 8'h18;
  localparam logic [7:0] RAH_REG_SRV_PA  = 8'h1c;
  localparam logic [7:0] RAH_REG_SRV_LO  = 8'h20;
  localparam logic [7:0] RAH_REG_SRV_HI  = 8'h24;

  // ==========================================================
  // Field positions
  localparam int RAH_CTRL_START = 0;
  localparam int RAH_ST_BUSY    = 0;
  localparam int RAH_ST_DONE    = 1;
  localparam int RAH_ST_TOUT    = 2;
  localparam int RAH_ST_FWD     = 3;
  localparam int RAH_ST_BADOP   = 4;

  // ==========================================================
  // Timing
  localparam int RAH_CLK_MHZ     = 125;
  localparam int RAH_TIMEOUT_US  = 1000000;
  localparam int RAH_TIMEOUT_CYC = RAH_TIMEOUT_US * RAH_CLK_MHZ;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [15:0] ftype;
    logic [15:0] hrd;
    logic [15:0] pro;
    logic [7:0]  hln;
    logic [7:0]  pln;
    logic [15:0] op;
    logic [47:0] sha;
    logic [31:0] spa;
    logic [47:0] tha;
    logic [31:0] tpa;
  } rah_pkt_type;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } rah_byte_type;

endpackage

// ---- src/rah_rx_parse.sv ----
// Receive byte collector that assembles one packet image
`timescale 1ns/10ps
module rah_rx_parse
(
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_b,
  // Received byte stream
  input  wire logic                 rx_valid,
  input  wire rah_pkg::rah_byte_type rx_byte,
  // Assembled packet
  output logic                      pkt_valid,
  output rah_pkg::rah_pkt_type      pkt
);
  import rah_pkg::*;

  logic [239:0] shift_q;
  logic [4:0]   count_q;
  logic         over_q;
  logic         pkt_valid_q;

  // ==========================================================
  // Byte shifting, first byte ends most significant
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shift_q <= '0;
      count_q <= 5'h00;
      over_q  <= 1'b0;
    end
    else if (rx_valid)
    begin
      shift_q <= {shift_q[231:0], rx_byte.data};
      if (rx_byte.last)
      begin
        count_q <= 5'h00;
        over_q  <= 1'b0;
      end
      else if (count_q == RAH_PKT_BYTES)
        over_q  <= 1'b1;
      else
        count_q <= count_q + 5'h01;
    end
  end

  // ==========================================================
  // Accept only frames of exactly the packet length
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      pkt_valid_q <= 1'b0;
    else
      pkt_valid_q <= rx_valid && rx_byte.last && !over_q
                     && (count_q == RAH_PKT_BYTES - 5'h01);
  end

  assign pkt_valid = pkt_valid_q;
  assign pkt       = rah_pkt_type'(shift_q);

endmodule

// ---- tb/rah_host_assertions.sv ----
// Checker for the host transmit stream and forward hand-off
`timescale 1ns/10ps
module rah_chk
#(
  parameter logic [15:0] rev_frame_type = 16'h5a01
)
(
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_b,
  // Streams
  input  wire logic                  tx_valid,
  input  wire rah_pkg::rah_byte_type tx_byte,
  input  wire logic                  tx_ready,
  input  wire logic                  fwd_valid,
  input  wire rah_pkg::rah_pkt_type  fwd_pkt
);
  import rah_pkg::*;
  // ==========================================================
  // Byte index
  logic [4:0]  idx_q;
  logic [79:0] hdr;
  logic [7:0]  hdr_b;
  assign hdr = {rev_frame_type, 16'h0001, 16'h0800, 8'h06, 8'h04, 16'h0003};
  assign hdr_b = hdr[79 - 8 * int'(idx_q) -: 8];
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
      idx_q <= 5'h00;
    else if (tx_valid && tx_ready)
      idx_q <= tx_byte.last ? 5'h00 : idx_q + 5'h01;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // Assertions
  property p_tx_ftype; tx_valid && idx_q < 5'h02 |-> tx_byte.data == hdr_b; endproperty
  a_tx_ftype: assert property (p_tx_ftype) else $error("frame type byte");
  property p_tx_space;
    tx_valid && idx_q inside {[5'h02:5'h05]} |-> tx_byte.data == hdr_b;
  endproperty
  a_tx_space: assert property (p_tx_space) else $error("space code byte");
  property p_tx_len;
    tx_valid && idx_q inside {5'h06, 5'h07} |-> tx_byte.data == hdr_b;
  endproperty
  a_tx_len: assert property (p_tx_len) else $error("length byte");
  property p_tx_op;
    tx_valid && idx_q inside {5'h08, 5'h09} |-> tx_byte.data == hdr_b;
  endproperty
  a_tx_op: assert property (p_tx_op) else $error("opcode byte");
  property p_tx_last; tx_valid |-> tx_byte.last == (idx_q == 5'h1d); endproperty
  a_tx_last: assert property (p_tx_last) else $error("packet length");
  property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("byte dropped");
  property p_fwd_pulse; fwd_valid |=> !fwd_valid; endproperty
  a_fwd_pulse: assert property (p_fwd_pulse) else $error("hand-off pulse");
  property p_fwd_op; fwd_valid |-> fwd_pkt.op inside {16'h0001, 16'h0002}; endproperty
  a_fwd_op: assert property (p_fwd_op) else $error("hand-off opcode");
  c_last: cover property (tx_valid && tx_ready && tx_byte.last);
  c_stall: cover property (tx_valid && !tx_ready);
  c_fwd: cover property (fwd_valid);
endmodule
bind rah_host rah_chk #(.rev_frame_type(rev_frame_type)) i_chk
  (.ref_clk, .rst_b, .tx_valid, .tx_byte, .tx_ready, .fwd_valid, .fwd_pkt);

// ---- tb/rah_srv_model.sv ----
// Behavioural remote server answering reverse requests
`timescale 1ns/10ps
module rah_srv_model
(
  // Clock and stream
  input  wire logic                  ref_clk,
  input  wire logic                  tx_valid,
  input  wire rah_pkg::rah_byte_type tx_byte,
  output logic                       tx_ready,
  output logic                       rx_valid,
  output rah_pkg::rah_byte_type      rx_byte,
  // Controls and results
  input  wire logic                  slow,
  input  wire logic [15:0]           op_sel,
  input  wire logic [47:0]           known_ha,
  input  wire logic [47:0]           srv_ha,
  input  wire logic [31:0]           srv_pa,
  input  wire logic [31:0]           res_pa,
  output rah_pkg::rah_pkt_type       req,
  output int                         req_count,
  output int                         rep_count
);
  import rah_pkg::*;
  rah_pkt_type rep;
  initial
  begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_byte = 9'h000;
    req = '0;
    req_count = 0;
    rep_count = 0;
    forever
    begin
      @(posedge ref_clk);
      tx_ready <= slow ? ~tx_ready : 1'b1;
      if (tx_valid && tx_ready)
      begin
        req = {req[231:0], tx_byte.data};
        if (tx_byte.last)
        begin
          req_count++;
          if (req.tha == known_ha)
          begin
            rep = req;
            rep.ftype = 16'h5a01;
            rep.hrd = RAH_HRD_ETH;
            rep.pro = RAH_PRO_IP;
            rep.hln = RAH_HLN;
            rep.pln = RAH_PLN;
            rep.op = op_sel;
            rep.sha = srv_ha;
            rep.spa = srv_pa;
            rep.tpa = res_pa;
            repeat (2) @(posedge ref_clk);
            for (int i = 0; i < 30; i++)
            begin
              rx_valid <= 1'b1;
              rx_byte <= {rep[239 - 8 * i -: 8], i == 29};
              @(posedge ref_clk);
            end
            rx_valid <= 1'b0;
            rx_byte <= {~rep[7:0], 1'b0};
            rep_count++;
          end
        end
      end
    end
  end
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the reverse resolution host
`timescale 1ns/10ps
module testbench;
  import rah_pkg::*;
  logic ref_clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_bready, s_axi_rready, tx_valid, tx_ready, rx_valid, fwd_valid, slow;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, srv_pa, res_pa;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] op_sel;
  logic [47:0] own, known_ha, srv_ha;
  rah_byte_type tx_byte, rx_byte;
  rah_pkt_type fwd_pkt, req;
  int req_count, rep_count, bad_count, check_count;
  int unsigned seed_v;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [15:0] fq[$];
  logic [15:0] op_tab[5] = '{16'h0004, 16'h0001, 16'h0002, 16'h0005, 16'h0004};
  logic [31:0] st_tab[5] = '{32'h02, 32'h0c, 32'h0c, 32'h14, 32'h04};
  rah_host #(.timeout_cyc(200)) i_dut (.ref_clk, .rst_b, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .tx_valid, .tx_byte,
    .tx_ready, .rx_valid, .rx_byte, .fwd_valid, .fwd_pkt);
  rah_srv_model i_srv (.ref_clk, .tx_valid, .tx_byte, .tx_ready, .rx_valid, .rx_byte,
    .slow, .op_sel, .known_ha, .srv_ha, .srv_pa, .res_pa, .req, .req_count, .rep_count);
  // ==========================================================
  // Checking
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    if (s_axi_rvalid && s_axi_rready)
      check("read", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready)
      check("bresp", s_axi_bresp, bq.pop_front());
    if (fwd_valid)
    begin
      check("fwd_op", fwd_pkt.op, fq.size() > 0 ? fq.pop_front() : 16'hffff);
      check("fwd_tpa", fwd_pkt.tpa, res_pa);
    end
  end
  // ==========================================================
  // Bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    forever
    begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] exp);
    rq.push_back(exp);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    forever
    begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
  endtask
  // ==========================================================
  // Stimulus
  initial
  begin
    ref_clk = 1'b0;
    forever
      #4 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    bad_count++;
    complete_run();
  end
  initial
  begin
    {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, slow} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, op_sel} = 64'h0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
    seed_v = $urandom(32'hb98f);
    {known_ha, srv_ha, srv_pa, res_pa} = {$urandom, $urandom, $urandom, $urandom, $urandom};
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rd(RAH_REG_STATUS, 34'h0);
    rd(8'h28, {2'b10, 32'h0});
    wr(8'h28, 32'h1, 2'b10);
    for (int k = 0; k < 5; k++)
    begin
      own = {16'($urandom), $urandom};
      known_ha <= (k == 4) ? ~own : own;
      slow <= k[0];
      op_sel <= op_tab[k];
      if (k == 1 || k == 2)
        fq.push_back(op_tab[k]);
      wr(RAH_REG_OWN_LO, own[31:0], 2'b00);
      wr(RAH_REG_OWN_HI, {16'h0, own[47:32]}, 2'b00);
      wr(RAH_REG_TGT_LO, own[31:0], 2'b00);
      wr(RAH_REG_TGT_HI, {16'h0, own[47:32]}, 2'b00);
      wr(RAH_REG_CTRL, 32'h1, 2'b00);
      while (req_count == k)
        @(posedge ref_clk);
      check("ftype", req.ftype, 16'h5a01);
      check("hrd", req.hrd, RAH_HRD_ETH);
      check("pro", req.pro, RAH_PRO_IP);
      check("lens", {req.hln, req.pln}, 16'h0604);
      check("op", req.op, RAH_OP_RREQ);
      check("sha", req.sha, own);
      check("tha", req.tha, own);
      repeat (300) @(posedge ref_clk);
      rd(RAH_REG_STATUS, {2'b00, st_tab[k]});
      if (k == 0)
      begin
        rd(RAH_REG_RES_PA, {2'b00, res_pa});
        rd(RAH_REG_SRV_PA, {2'b00, srv_pa});
        rd(RAH_REG_SRV_LO, {2'b00, srv_ha[31:0]});
        rd(RAH_REG_SRV_HI, {18'h0, srv_ha[47:32]});
      end
      wr(RAH_REG_STATUS, 32'h1f, 2'b00);
      rd(RAH_REG_STATUS, 34'h0);
      check("fwd_left", fq.size(), 0);
    end
    check("replies", rep_count, 4);
    repeat (4) @(posedge ref_clk);
    complete_run();
  end
endmodule
